// [src/ripc_ctrl.sv]
/*
  Reset, idle, power-down and test-mode sequencer for an 8-bit core.
  Assumes osc_input is the oscillator clock level sampled in clk, and that
  the core pulses instr_done at the end of each instruction.
*/
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module ripc_ctrl (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       por,
  // pins
  input  wire logic       rst_pin,
  input  wire logic       osc_input,
  input  wire logic       latch_strobe_in,
  input  wire logic       program_fetch_strobe_in,
  input  wire logic       ext_interrupt_a,
  input  wire logic       ext_interrupt_b,
  // core side
  input  wire logic       instr_done,
  input  wire logic       irq_pending,
  input  wire logic       ext_a_en_level,
  input  wire logic       ext_b_en_level,
  input  wire logic       interrupt_return_instr,
  input  wire logic       ext_progmem,
  input  wire logic       no_progmem_variant,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata_q,
  // controls
  output logic            clk_half_q,
  output logic            cpu_run_q,
  output logic            periph_run_q,
  output logic            osc_enable_q,
  output logic            sfr_reset_q,
  output logic            ram_wr_block_q,
  output logic            progmem_analog_off_q,
  output logic            wake_vector_q,
  output logic            test_mode_q,
  // pin states
  output logic            latch_strobe_q,
  output logic            program_fetch_strobe_q,
  output logic [1:0]      port0_mode_q,
  output logic [1:0]      port1_mode_q,
  output logic [1:0]      port2_mode_q,
  output logic [1:0]      port3_mode_q
);
  ripc_pkg::ripc_mode_e mode_q;
  logic [7:0] pcon_q;
  logic [7:0] aux_one_q;
  logic       rst_valid;
  logic       osc_prev_q;
  logic       test_arm_q;
  logic       rst_pin_prev_q;
  logic [ripc_pkg::CNT_W-1:0] idle_rst_cnt_q;
  logic       idle_rst_q;
  logic       wake_allowed;
  logic       wake_low;
  logic       wake_active_q;
  logic       ret_pending_q;
  logic       full_rst;

  ripc_reset_filter u_filter (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .rst_pin     (rst_pin),
    .rst_valid_q (rst_valid)
  );

  assign full_rst = sys_rst || rst_valid;

  // ==========================================================
  // clock halving
  // divide oscillator by two
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      osc_prev_q <= 1'b0;
      clk_half_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_input;
      // no gating by osc_enable_q: a rise launched as the oscillator stops
      // must still count, or the half-rate phase slips at each power-down
      if (osc_input && !osc_prev_q) begin
        clk_half_q <= !clk_half_q;
      end
    end
  end

  // ==========================================================
  // wake qualification
  // wake enable gates interrupt wakeup
  assign wake_allowed = aux_one_q[ripc_pkg::WAKE_EN_BIT] || no_progmem_variant;
  assign wake_low = (ext_a_en_level && !ext_interrupt_a) ||
                    (ext_b_en_level && !ext_interrupt_b);

  // ==========================================================
  // mode machine
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_q <= ripc_pkg::RIPC_RUN;
    end else begin
      case (mode_q)
        ripc_pkg::RIPC_RUN: begin
          if (instr_done && pcon_q[ripc_pkg::PDOWN_BIT]) begin
            mode_q <= ripc_pkg::RIPC_PDOWN;
          end else if (instr_done && pcon_q[ripc_pkg::IDLE_BIT]) begin
            mode_q <= ripc_pkg::RIPC_IDLE;
          end
        end
        ripc_pkg::RIPC_IDLE: begin
          if (full_rst || irq_pending) begin
            mode_q <= ripc_pkg::RIPC_RUN;
          end
        end
        ripc_pkg::RIPC_PDOWN: begin
          // raw pin: qualification needs the oscillator, which is stopped
          if (rst_pin) begin
            mode_q <= ripc_pkg::RIPC_RUN;
          end else if (wake_allowed && wake_low) begin
            mode_q <= ripc_pkg::RIPC_WAKE;
          end
        end
        ripc_pkg::RIPC_WAKE: begin
          // oscillator already runs again; the pin's return ends the exit
          // exit completes on pin high
          if (!wake_low) begin
            mode_q <= ripc_pkg::RIPC_RUN;
          end
        end
        ripc_pkg::RIPC_TEST: begin
          if (rst_valid && latch_strobe_in) begin
            mode_q <= ripc_pkg::RIPC_RUN;
          end
        end
        default: mode_q <= ripc_pkg::RIPC_RUN;
      endcase
      // arm is taken while the pin is high, so a latch strobe that only
      // drops at release is not enough
      // test entry at reset release
      if (rst_pin_prev_q && !rst_pin && test_arm_q && !latch_strobe_in) begin
        mode_q <= ripc_pkg::RIPC_TEST;
      end
    end
  end

  // test entry arm and reset edge tracking
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      test_arm_q     <= 1'b0;
      rst_pin_prev_q <= 1'b0;
    end else begin
      rst_pin_prev_q <= rst_pin;
      if (!rst_pin) begin
        test_arm_q <= 1'b0;
      end else if (!latch_strobe_in && program_fetch_strobe_in) begin
        test_arm_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // idle reset window: the core may still run briefly, ram writes blocked
  // opens on the pin's rising edge in idle and lasts two machine cycles;
  // a longer pin pulse must not stretch it into the normal run that
  // follows the internal reset
  // block ram writes during window
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      idle_rst_cnt_q <= '0;
      idle_rst_q     <= 1'b0;
    end else if (mode_q == ripc_pkg::RIPC_IDLE && rst_pin && !rst_pin_prev_q) begin
      idle_rst_q     <= 1'b1;
      idle_rst_cnt_q <= ripc_pkg::CNT_W'(ripc_pkg::IDLE_RST_CYC - 1);
    end else if (idle_rst_cnt_q != '0) begin
      idle_rst_cnt_q <= idle_rst_cnt_q - 1'b1;
    end else begin
      idle_rst_q <= 1'b0;
    end
  end

  // ==========================================================
  // wake return tracking
  // resume after return instruction
  always_ff @(posedge clk) begin
    if (sys_rst || full_rst) begin
      ret_pending_q <= 1'b0;
      wake_vector_q <= 1'b0;
    end else begin
      wake_vector_q <= (mode_q == ripc_pkg::RIPC_WAKE) && !wake_low;
      if (mode_q == ripc_pkg::RIPC_WAKE && !wake_low) begin
        ret_pending_q <= 1'b1;
      end else if (interrupt_return_instr) begin
        ret_pending_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // power control register
  // power-on flag set by power-on or by a register write, kept over pin reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pcon_q <= por ? ripc_pkg::PCON_RST_POR : ripc_pkg::PCON_RST;
    end else if (rst_valid) begin
      pcon_q <= {3'b000, pcon_q[ripc_pkg::POF_BIT], 4'h0};
    end else begin
      if (reg_wr && reg_addr == ripc_pkg::PCON_ADDR) begin
        pcon_q <= reg_wdata & ripc_pkg::PCON_MASK;
      end
      if (mode_q == ripc_pkg::RIPC_IDLE && irq_pending) begin
        pcon_q[ripc_pkg::IDLE_BIT] <= 1'b0;
      end
      if (mode_q == ripc_pkg::RIPC_WAKE && !wake_low) begin
        pcon_q[ripc_pkg::PDOWN_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || rst_valid) begin
      aux_one_q <= ripc_pkg::AUX_ONE_RST;
    end else if (reg_wr && reg_addr == ripc_pkg::AUX_ONE_ADDR) begin
      aux_one_q <= reg_wdata & ripc_pkg::AUX_ONE_MASK;
    end
  end

  // read port
  // unmapped and idle cycles return zero so no stale value stands
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd && reg_addr == ripc_pkg::PCON_ADDR) begin
      reg_rdata_q <= pcon_q;
    end else if (reg_rd && reg_addr == ripc_pkg::AUX_ONE_ADDR) begin
      reg_rdata_q <= aux_one_q;
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // ==========================================================
  // core and clock controls
  // registers hold while clock gated
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cpu_run_q            <= 1'b1;
      periph_run_q         <= 1'b1;
      osc_enable_q         <= 1'b1;
      sfr_reset_q          <= 1'b1;
      ram_wr_block_q       <= 1'b0;
      progmem_analog_off_q <= 1'b0;
      test_mode_q          <= 1'b0;
      wake_active_q        <= 1'b0;
    end else begin
      cpu_run_q    <= (mode_q == ripc_pkg::RIPC_RUN) ||
                      (mode_q == ripc_pkg::RIPC_TEST);
      periph_run_q <= (mode_q != ripc_pkg::RIPC_PDOWN);
      osc_enable_q <= (mode_q != ripc_pkg::RIPC_PDOWN);
      // one pulse per qualified reset; the registers reload from it
      sfr_reset_q  <= rst_valid;
      ram_wr_block_q <= idle_rst_q;
      progmem_analog_off_q <= aux_one_q[ripc_pkg::ANALOG_OFF_BIT];
      test_mode_q   <= (mode_q == ripc_pkg::RIPC_TEST);
      wake_active_q <= ret_pending_q;
    end
  end

  // ==========================================================
  // pin states
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      latch_strobe_q         <= 1'b1;
      program_fetch_strobe_q <= 1'b1;
      port0_mode_q           <= ripc_pkg::PIN_DATA;
      port1_mode_q           <= ripc_pkg::PIN_DATA;
      port2_mode_q           <= ripc_pkg::PIN_DATA;
      port3_mode_q           <= ripc_pkg::PIN_DATA;
    end else begin
      case (mode_q)
        ripc_pkg::RIPC_IDLE: begin
          latch_strobe_q         <= 1'b1;
          program_fetch_strobe_q <= 1'b1;
          port0_mode_q <= ext_progmem ? ripc_pkg::PIN_FLOAT : ripc_pkg::PIN_DATA;
          port1_mode_q <= ripc_pkg::PIN_DATA;
          port2_mode_q <= ext_progmem ? ripc_pkg::PIN_ADDR : ripc_pkg::PIN_DATA;
          port3_mode_q <= ripc_pkg::PIN_DATA;
        end
        ripc_pkg::RIPC_PDOWN, ripc_pkg::RIPC_WAKE: begin
          latch_strobe_q         <= 1'b0;
          program_fetch_strobe_q <= 1'b0;
          port0_mode_q <= ext_progmem ? ripc_pkg::PIN_FLOAT : ripc_pkg::PIN_DATA;
          port1_mode_q <= ripc_pkg::PIN_DATA;
          port2_mode_q <= ripc_pkg::PIN_DATA;
          port3_mode_q <= ripc_pkg::PIN_DATA;
        end
        ripc_pkg::RIPC_TEST: begin
          latch_strobe_q         <= 1'b1;
          program_fetch_strobe_q <= 1'b1;
          port0_mode_q <= ripc_pkg::PIN_FLOAT;
          port1_mode_q <= ripc_pkg::PIN_WEAK;
          port2_mode_q <= ripc_pkg::PIN_WEAK;
          port3_mode_q <= ripc_pkg::PIN_WEAK;
        end
        // normal run: strobes idle high, every port holds data
        ripc_pkg::RIPC_RUN: begin
          latch_strobe_q         <= 1'b1;
          program_fetch_strobe_q <= 1'b1;
          port0_mode_q <= ripc_pkg::PIN_DATA;
          port1_mode_q <= ripc_pkg::PIN_DATA;
          port2_mode_q <= ripc_pkg::PIN_DATA;
          port3_mode_q <= ripc_pkg::PIN_DATA;
        end
        default: begin
          latch_strobe_q         <= 1'b1;
          program_fetch_strobe_q <= 1'b1;
          port0_mode_q <= ripc_pkg::PIN_DATA;
          port1_mode_q <= ripc_pkg::PIN_DATA;
          port2_mode_q <= ripc_pkg::PIN_DATA;
          port3_mode_q <= ripc_pkg::PIN_DATA;
        end
      endcase
    end
  end

endmodule : ripc_ctrl

// [shared/ripc_pkg.sv]
/*
  Constants, states and pin codes for the reset / idle / power-down controller.
  Assumes a single 25 MHz system clock and a synchronous active-high reset.
*/
// Contract
// - oscillator input divided by two before any internal use
// - ram and register contents kept while clock slows or stops
// - idle halts execution, peripherals stay clocked, state preserved
// - requesting instruction completes, nothing further runs before idle
// - idle ends on enabled interrupt (to its handler) or on full reset
// - power-down stops oscillator after requesting instruction, nothing runs
// - reset exit reinitialises registers keeps ram; interrupt exit keeps both
// - wake enable bit: 0 blocks, 1 permits interrupt wakeup from power-down
// - level interrupt low restarts oscillator, return high completes exit
// - after interrupt return, execution resumes after power-down instruction
// - variant without program memory always allows interrupt wakeup
// - analog-off bit drives power-off control to program memory analog
// - reset in idle: up to two machine cycles run, ram writes blocked
// - test mode floats port 0, pulls others and strobes weakly high
// - idle: strobes 1, ports 1,3 data, external memory port0 float
// - power-down: strobes 0, ports 1-3 data, port0 float if external
// - some power-control reset values depend on the reset source
package ripc_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] PCON_ADDR     = 8'h87;
  localparam logic [7:0] AUX_ONE_ADDR  = 8'hA2;
  localparam logic [7:0] AUX_ADDR      = 8'h8E;

  // power control fields
  localparam int IDLE_BIT      = 0;
  localparam int PDOWN_BIT     = 1;
  localparam int GF0_BIT       = 2;
  localparam int GF1_BIT       = 3;
  localparam int POF_BIT       = 4;
  // aux one fields
  localparam int WAKE_EN_BIT   = 3;
  localparam int ANALOG_OFF_BIT = 4;

  localparam logic [7:0] PCON_RST_POR  = 8'h10;
  localparam logic [7:0] PCON_RST      = 8'h00;
  localparam logic [7:0] AUX_ONE_RST   = 8'h00;
  localparam logic [7:0] PCON_MASK     = 8'hDF;
  localparam logic [7:0] AUX_ONE_MASK  = 8'h19;

  // ==========================================================
  // timing
  localparam int OSC_PER_MC    = 12;
  localparam int RST_MIN_OSC   = 24;
  localparam int RST_MIN_CYC   = RST_MIN_OSC;
  localparam int IDLE_RST_MC   = 2;
  localparam int IDLE_RST_CYC  = IDLE_RST_MC * OSC_PER_MC / 2;
  localparam int CNT_W         = 5;

  // ==========================================================
  // modes
  typedef enum logic [4:0] {
    RIPC_RUN   = 5'b0_0001,
    RIPC_IDLE  = 5'b0_0010,
    RIPC_PDOWN = 5'b0_0100,
    RIPC_WAKE  = 5'b0_1000,
    RIPC_TEST  = 5'b1_0000
  } ripc_mode_e;

  // port drive codes
  localparam logic [1:0] PIN_DATA  = 2'h0;
  localparam logic [1:0] PIN_FLOAT = 2'h1;
  localparam logic [1:0] PIN_ADDR  = 2'h2;
  localparam logic [1:0] PIN_WEAK  = 2'h3;

endpackage : ripc_pkg

// [src/ripc_reset_filter.sv]
/*
  Reset pin qualifier: counts consecutive high samples of the reset pin.
  Assumes the pin is already synchronous to clk.
*/
`timescale 1ns/1ps
module ripc_reset_filter (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // pin
  input  wire logic rst_pin,
  // qualified reset
  output logic      rst_valid_q
);
  logic [ripc_pkg::CNT_W-1:0] cnt_q;

  // ==========================================================
  // counter
  // qualify minimum width
  always_ff @(posedge clk) begin
    if (sys_rst || !rst_pin) begin
      cnt_q <= '0;
    end else if (cnt_q != ripc_pkg::CNT_W'(ripc_pkg::RST_MIN_CYC)) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rst_valid_q <= 1'b0;
    end else begin
      rst_valid_q <= rst_pin && (cnt_q == ripc_pkg::CNT_W'(ripc_pkg::RST_MIN_CYC - 1));
    end
  end
endmodule : ripc_reset_filter

// [bench/ripc_partner.sv]
/*
  Far side of the controller: reset source, wake interrupt source, oscillator
  and emulator strobes. Assumes the bench clock; pins move after rising edges.
*/
`timescale 1ns/1ps
module ripc_partner (
  // clock and device state
  input  wire logic clk,
  input  wire logic osc_enable_q,
  // pins
  output logic      rst_pin,
  output logic      osc_input,
  output logic      latch_strobe_in,
  output logic      program_fetch_strobe_in,
  output logic      ext_interrupt_a,
  output logic      ext_interrupt_b
);
  // ==========================================================
  // pin levels
  initial begin
    rst_pin = 1'b0;
    osc_input = 1'b0;
    latch_strobe_in = 1'b1;
    program_fetch_strobe_in = 1'b1;
    ext_interrupt_a = 1'b1;
    ext_interrupt_b = 1'b1;
  end

  // oscillator stands still while the device has it stopped
  always @(posedge clk) begin
    if (osc_enable_q) begin
      osc_input <= !osc_input;
    end
  end

  // ==========================================================
  // sequences
  // long reset, optional latch low
  task automatic hold_reset(input int n, input logic latch_lo);
    @(posedge clk);
    rst_pin <= 1'b1;
    latch_strobe_in <= !latch_lo;
    repeat (n) @(posedge clk);
    rst_pin <= 1'b0;
    repeat (2) @(posedge clk);
    latch_strobe_in <= 1'b1;
  endtask : hold_reset

  task automatic wake_low(input int n);
    @(posedge clk);
    ext_interrupt_a <= 1'b0;
    repeat (n) @(posedge clk);
    ext_interrupt_a <= 1'b1;
  endtask : wake_low
endmodule : ripc_partner

// [bench/ripc_ctrl_asserts.sv]
/*
  Port checker for ripc_ctrl, bound at the foot of this file.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module ripc_ctrl_asserts (
  // clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // inputs
  input wire logic       rst_pin,
  input wire logic       instr_done,
  input wire logic       ext_progmem,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  // outputs
  input wire logic [7:0] reg_rdata_q,
  input wire logic       cpu_run_q,
  input wire logic       periph_run_q,
  input wire logic       osc_enable_q,
  input wire logic       sfr_reset_q,
  input wire logic       ram_wr_block_q,
  input wire logic       progmem_analog_off_q,
  input wire logic       wake_vector_q,
  input wire logic       test_mode_q,
  input wire logic       latch_strobe_q,
  input wire logic       program_fetch_strobe_q,
  input wire logic [1:0] port0_mode_q,
  input wire logic [1:0] port1_mode_q,
  input wire logic [1:0] port3_mode_q
);
  // ==========================================================
  // helpers
  logic [4:0] hi_cnt_q;
  always_ff @(posedge clk) begin
    if (sys_rst || !rst_pin) begin
      hi_cnt_q <= 5'h00;
    end else if (hi_cnt_q != 5'h1F) begin
      hi_cnt_q <= hi_cnt_q + 5'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence pcon_req(logic [7:0] v);
    reg_wr && reg_addr == ripc_pkg::PCON_ADDR && reg_wdata == v ##1 instr_done;
  endsequence

  // ==========================================================
  // properties
  reset_state_a:
    assert property (disable iff (1'b0) sys_rst |=> cpu_run_q && osc_enable_q
      && latch_strobe_q && program_fetch_strobe_q) else $error("reset state wrong");
  rd_stands_a:
    assert property (!$past(reg_rd) |-> reg_rdata_q == 8'h00) else $error("stale read data");
  idle_entry_a:
    assert property (pcon_req(8'h01) |-> ##[1:2] (!cpu_run_q && periph_run_q
      && latch_strobe_q && program_fetch_strobe_q)) else $error("idle not entered");
  pdown_entry_a:
    assert property (pcon_req(8'h02) |-> ##[1:2] (!osc_enable_q && !cpu_run_q))
      else $error("power-down not entered");
  pdown_pins_a:
    assert property (!osc_enable_q |-> !latch_strobe_q && !program_fetch_strobe_q
      && port1_mode_q == ripc_pkg::PIN_DATA && port3_mode_q == ripc_pkg::PIN_DATA
      && port0_mode_q == (ext_progmem ? ripc_pkg::PIN_FLOAT : ripc_pkg::PIN_DATA))
      else $error("power-down pins wrong");
  analog_off_a:
    assert property (reg_wr && reg_addr == ripc_pkg::AUX_ONE_ADDR && reg_wdata[4]
      && !rst_pin |-> ##[1:2] progmem_analog_off_q) else $error("analog off not set");
  wake_pulse_a:
    assert property (wake_vector_q |-> osc_enable_q ##1 !wake_vector_q)
      else $error("wake pulse wrong");
  ram_block_a:
    assert property ($rose(ram_wr_block_q) |-> $past(rst_pin)) else $error("stray ram block");
  test_pins_a:
    assert property (test_mode_q && $past(test_mode_q) |-> latch_strobe_q
      && program_fetch_strobe_q && port0_mode_q == ripc_pkg::PIN_FLOAT
      && port1_mode_q == ripc_pkg::PIN_WEAK && port3_mode_q == ripc_pkg::PIN_WEAK)
      else $error("test mode pins wrong");
  reset_qual_a:
    assert property ($rose(sfr_reset_q) |-> hi_cnt_q >= 5'h18 || !$past(osc_enable_q, 2))
      else $error("reset taken too early");
endmodule : ripc_ctrl_asserts

bind ripc_ctrl ripc_ctrl_asserts u_chk (
  .clk(clk), .sys_rst(sys_rst), .rst_pin(rst_pin), .instr_done(instr_done),
  .ext_progmem(ext_progmem), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .cpu_run_q(cpu_run_q),
  .periph_run_q(periph_run_q), .osc_enable_q(osc_enable_q), .sfr_reset_q(sfr_reset_q),
  .ram_wr_block_q(ram_wr_block_q), .progmem_analog_off_q(progmem_analog_off_q),
  .wake_vector_q(wake_vector_q), .test_mode_q(test_mode_q), .latch_strobe_q(latch_strobe_q),
  .program_fetch_strobe_q(program_fetch_strobe_q), .port0_mode_q(port0_mode_q),
  .port1_mode_q(port1_mode_q), .port3_mode_q(port3_mode_q)
);

// [bench/tb.sv]
/*
  Self-checking bench for ripc_ctrl: register port, low-power modes, test mode.
  Assumes ripc_partner stands for the pins and a 25 MHz clock.
*/
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] A_PC = ripc_pkg::PCON_ADDR;
  localparam logic [7:0] A_AX = ripc_pkg::AUX_ONE_ADDR;
  localparam logic [1:0] DA = ripc_pkg::PIN_DATA, FL = ripc_pkg::PIN_FLOAT;
  localparam logic [1:0] AD = ripc_pkg::PIN_ADDR, WK = ripc_pkg::PIN_WEAK;
  logic       clk = 1'b0, sys_rst = 1'b1, por = 1'b1, instr_done = 1'b0, irq_pending = 1'b0;
  logic       ext_a_en_level = 1'b1, ext_b_en_level = 1'b0, interrupt_return_instr = 1'b0;
  logic       ext_progmem = 1'b1, no_progmem_variant = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_q, q;
  logic       clk_half_q, cpu_run_q, periph_run_q, osc_enable_q, sfr_reset_q, ram_wr_block_q;
  logic       progmem_analog_off_q, wake_vector_q, test_mode_q;
  logic       latch_strobe_q, program_fetch_strobe_q;
  logic [1:0] port0_mode_q, port1_mode_q, port2_mode_q, port3_mode_q;
  logic       rst_pin, osc_input, latch_strobe_in, program_fetch_strobe_in;
  logic       ext_interrupt_a, ext_interrupt_b, osc_prev = 1'b0, half_prev = 1'b0;
  int         n_errors = 0, checked = 0, cyc = 0, n_wake = 0, n_blk = 0, n_osc = 0, n_half = 0;
  wire  [9:0] pins = {latch_strobe_q, program_fetch_strobe_q, port0_mode_q, port1_mode_q,
                      port2_mode_q, port3_mode_q};

  always #20 clk = ~clk;

  ripc_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .por(por), .rst_pin(rst_pin),
    .osc_input(osc_input), .latch_strobe_in(latch_strobe_in),
    .program_fetch_strobe_in(program_fetch_strobe_in), .ext_interrupt_a(ext_interrupt_a),
    .ext_interrupt_b(ext_interrupt_b), .instr_done(instr_done), .irq_pending(irq_pending),
    .ext_a_en_level(ext_a_en_level), .ext_b_en_level(ext_b_en_level),
    .interrupt_return_instr(interrupt_return_instr), .ext_progmem(ext_progmem),
    .no_progmem_variant(no_progmem_variant), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .clk_half_q(clk_half_q),
    .cpu_run_q(cpu_run_q), .periph_run_q(periph_run_q), .osc_enable_q(osc_enable_q),
    .sfr_reset_q(sfr_reset_q), .ram_wr_block_q(ram_wr_block_q),
    .progmem_analog_off_q(progmem_analog_off_q), .wake_vector_q(wake_vector_q),
    .test_mode_q(test_mode_q), .latch_strobe_q(latch_strobe_q),
    .program_fetch_strobe_q(program_fetch_strobe_q), .port0_mode_q(port0_mode_q),
    .port1_mode_q(port1_mode_q), .port2_mode_q(port2_mode_q), .port3_mode_q(port3_mode_q));

  ripc_partner u_part (.clk(clk), .osc_enable_q(osc_enable_q), .rst_pin(rst_pin),
    .osc_input(osc_input), .latch_strobe_in(latch_strobe_in),
    .program_fetch_strobe_in(program_fetch_strobe_in), .ext_interrupt_a(ext_interrupt_a),
    .ext_interrupt_b(ext_interrupt_b));

  // ==========================================================
  // monitors and watchdog
  always @(posedge clk) begin
    cyc <= cyc + 1;
    osc_prev <= osc_input;
    half_prev <= clk_half_q;
    if (wake_vector_q === 1'b1) n_wake <= n_wake + 1;
    if (ram_wr_block_q === 1'b1) n_blk <= n_blk + 1;
    if (!sys_rst && osc_input && !osc_prev) n_osc <= n_osc + 1;
    if (!sys_rst && clk_half_q !== half_prev) n_half <= n_half + 1;
    if (cyc == 3000) begin
      n_errors++;
      conclude();
    end
  end

  // ==========================================================
  // tasks
  task automatic wr(input logic [7:0] a, d, input logic inst = 1'b0);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    instr_done <= inst;
    @(posedge clk);
    instr_done <= 1'b0;
  endtask : wr

  task automatic cmp(input logic [9:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic cmpb(input logic got, exp);
    cmp({9'h000, got}, {9'h000, exp});
  endtask : cmpb

  // read data stand only in the cycle after the strobe
  task automatic chk(input logic [7:0] a, exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata_q;
    cmp({2'b00, q}, {2'b00, exp});
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic conclude();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  // ==========================================================
  // sequence of tests
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    por <= 1'b0;
    chk(A_PC, ripc_pkg::PCON_RST_POR);
    chk(A_AX, ripc_pkg::AUX_ONE_RST);
    wr(A_PC, 8'h2C);
    chk(A_PC, 8'h2C & ripc_pkg::PCON_MASK);
    wr(8'h55, 8'hFF);
    chk(8'h55, 8'h00);
    wr(A_AX, 8'hFF);
    chk(A_AX, ripc_pkg::AUX_ONE_MASK);
    cmpb(progmem_analog_off_q, 1'b1);
    wr(A_AX, 8'h00);
    settle(1);
    cmpb(progmem_analog_off_q, 1'b0);
    // idle, then woken by an interrupt
    wr(A_PC, 8'h01, 1'b1);
    settle(2);
    cmpb(cpu_run_q, 1'b0);
    cmpb(periph_run_q, 1'b1);
    cmp(pins, {2'b11, FL, DA, AD, DA});
    chk(A_PC, 8'h01);
    irq_pending <= 1'b1;
    settle(3);
    irq_pending <= 1'b0;
    cmpb(cpu_run_q, 1'b1);
    chk(A_PC, 8'h00);
    // power-down: blocked wake, enabled wake, variant without program memory
    for (int i = 0; i < 3; i++) begin
      ext_progmem <= (i != 1);
      no_progmem_variant <= (i == 2);
      wr(A_AX, (i == 0) ? 8'h10 : (i == 1) ? 8'h08 : 8'h00);
      wr(A_PC, 8'h02, 1'b1);
      settle(2);
      cmpb(osc_enable_q, 1'b0);
      cmp(pins, {2'b00, (i != 1) ? FL : DA, DA, DA, DA});
      u_part.wake_low(8);
      settle(3);
      cmp(10'(n_wake), 10'(i));
      if (i == 0) begin
        cmpb(osc_enable_q, 1'b0);
        u_part.hold_reset(30, 1'b0);
        settle(3);
        chk(A_AX, 8'h00);
      end else begin
        interrupt_return_instr <= 1'b1;
        settle(1);
        interrupt_return_instr <= 1'b0;
        cmpb(cpu_run_q, 1'b1);
        chk(A_AX, (i == 1) ? 8'h08 : 8'h00);
      end
      chk(A_PC, 8'h00);
    end
    // reset during idle, internal program memory
    ext_progmem <= 1'b0;
    wr(A_PC, 8'h01, 1'b1);
    settle(2);
    cmp(pins, {2'b11, DA, DA, DA, DA});
    n_blk = 0;
    u_part.hold_reset(30, 1'b0);
    settle(4);
    cmp(10'(n_blk), 10'(ripc_pkg::IDLE_RST_CYC));
    cmpb(cpu_run_q, 1'b1);
    chk(A_PC, 8'h00);
    // test mode entry and exit
    u_part.hold_reset(30, 1'b1);
    settle(4);
    cmpb(test_mode_q, 1'b1);
    cmp(pins, {2'b11, FL, WK, WK, WK});
    cmpb(osc_enable_q, 1'b1);
    u_part.hold_reset(30, 1'b0);
    settle(2);
    cmpb(test_mode_q, 1'b0);
    // half-rate clock follows the oscillator rises
    cmpb((n_osc - n_half) inside {0, 1}, 1'b1);
    // mid-run system reset that is not a power-on
    wr(A_PC, 8'h0C);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    chk(A_PC, ripc_pkg::PCON_RST);
    conclude();
  end
endmodule : tb
